// ===== fsprm_pkg.sv
// Constants for the frame-sync and pin-buffer routing crossbar.
// Assumes a single 100 MHz clock and register access over AXI4-Lite.
// Function
// - Every frame-sync input of ports, converters, S/PDIF and input port gets routing.
// - Each frame-sync destination has its own 5-bit field picking one of 32 sources.
// - Frame-sync codes 0x00-0x13 pick pin buffer outputs 1 to 20.
// - Frame-sync codes 0x14-0x19 pick serial port 0-5 frame-sync outputs.
// - Code 0x1A picks S/PDIF receiver frame sync, 0x1B the transmitter biphase output.
// - Codes 0x1C and 0x1D pick precision frame-sync generator outputs A and B.
// - Frame-sync code 0x1E drives constant low, 0x1F constant high.
// - Each pin buffer input has its own 7-bit field picking any peripheral signal.
// - Pin codes 0x00-0x13 pick pin buffer outputs 1 to 20, allowing loopback.
// - Pin codes 0x14-0x1F pick serial port data, A on even code, B on odd.
// - Pin code 0x20 picks the serial port 0 clock output.
// - Bits 28 and 29 of pin_route_reg_4 invert pin buffer 19 and 20 inputs.
// - Inversion is defeated when the buffer's field selects its own output.
// - Pin codes 0x21-0x25 pick port 1-5 clocks, 0x26-0x2B port 0-5 frame syncs.
// - Pin code 0x50 drives low, 0x51 high; 0x52-0x7F are reserved.
package fsprm_pkg;
   localparam int FS_REGS = 4;
   localparam int PIN_REGS = 5;
   localparam int FS_PER_REG = 4;
   localparam int PIN_PER_REG = 4;
   localparam int FS_DESTS = 16;
   localparam int PINS = 20;
   localparam int FS_W = 5;
   localparam int PIN_W = 7;
   localparam int PORTS = 6;
   localparam int AUX_N = 36;
   // Byte offsets of the register map
   localparam logic [7:0] OFS_FS0 = 8'h00;
   localparam logic [7:0] OFS_PIN0 = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h24;
   // Register index codes returned by the decoder
   localparam logic [3:0] IDX_PIN0 = 4'h4;
   localparam logic [3:0] IDX_STAT = 4'h9;
   localparam logic [3:0] IDX_NONE = 4'hF;
   // Writable bits and reset values
   localparam logic [31:0] FS_WMASK = 32'h000F_FFFF;
   localparam logic [31:0] PIN_WMASK = 32'h0FFF_FFFF;
   localparam logic [31:0] PIN4_WMASK = 32'h3FFF_FFFF;
   localparam logic [31:0] RST_ROUTE = 32'h0000_0000;
   localparam int INV19_BIT = 28;
   localparam int INV20_BIT = 29;
   localparam int PB19 = 18;
   localparam int PB20 = 19;
   // Frame-sync source codes
   localparam logic [4:0] FS_C_PB = 5'h00;
   localparam logic [4:0] FS_C_SPFS = 5'h14;
   localparam logic [4:0] FS_C_RXFS = 5'h1A;
   localparam logic [4:0] FS_C_TXBI = 5'h1B;
   localparam logic [4:0] FS_C_PRECA = 5'h1C;
   localparam logic [4:0] FS_C_PRECB = 5'h1D;
   localparam logic [4:0] FS_C_LOW = 5'h1E;
   localparam logic [4:0] FS_C_HIGH = 5'h1F;
   // Pin-routing source codes
   localparam logic [6:0] PN_C_PB = 7'h00;
   localparam logic [6:0] PN_C_SPDAT = 7'h14;
   localparam logic [6:0] PN_C_SPCLK = 7'h20;
   localparam logic [6:0] PN_C_SPFS = 7'h26;
   localparam logic [6:0] PN_C_AUX = 7'h2C;
   localparam logic [6:0] PN_C_LOW = 7'h50;
   localparam logic [6:0] PN_C_HIGH = 7'h51;
   // Auxiliary codes 0x31-0x33 are reserved and read low
   localparam logic [35:0] AUX_RSVD = 36'h0_0000_00E0;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== fsprm_top.sv
// Frame-sync and pin-buffer routing crossbar with AXI4-Lite registers.
// Routing paths are combinational; only the configuration and bus state are clocked.
// Sources are assumed synchronous to CLK or purely combinational pass-through.
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module fsprm_top #(
   parameter int ADDR_W = 8
) (
   // Clock, reset, enable
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // AXI4-Lite write address
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   // AXI4-Lite write data
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read address
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   // AXI4-Lite read data
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Pin buffer outputs and inputs
   input wire logic [fsprm_pkg::PINS-1:0] PB_OUT,
   output logic [fsprm_pkg::PINS-1:0] PB_IN,
   // Serial port outputs
   input wire logic [fsprm_pkg::PORTS-1:0] SP_FSYNC_OUT,
   input wire logic [fsprm_pkg::PORTS-1:0] SP_CLOCK_OUT,
   input wire logic [fsprm_pkg::PORTS-1:0] SP_DATA_A_OUT,
   input wire logic [fsprm_pkg::PORTS-1:0] SP_DATA_B_OUT,
   // S/PDIF and precision frame-sync outputs
   input wire logic SPDIF_RX_FSYNC_OUT,
   input wire logic SPDIF_TX_BIPHASE_OUT,
   input wire logic PRECISION_FSYNC_A_OUT,
   input wire logic PRECISION_FSYNC_B_OUT,
   // Other pin-routing sources, codes 0x2C to 0x4F
   input wire logic [fsprm_pkg::AUX_N-1:0] AUX_SRC,
   // Frame-sync destinations
   output logic [fsprm_pkg::FS_DESTS-1:0] FS_DEST
);

   generate
      if (ADDR_W < 6) begin : g_chk
         $error("ADDR_W too small for the register map");
      end
   endgenerate

   typedef struct packed {
      logic [fsprm_pkg::FS_REGS-1:0][31:0] fs;
      logic [fsprm_pkg::PIN_REGS-1:0][31:0] pin;
      logic aw_got;
      logic [ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic b_valid;
      logic [1:0] b_resp;
      logic r_valid;
      logic [31:0] r_data;
      logic [1:0] r_resp;
   } fsprm_state_s;

   fsprm_state_s st_q;
   fsprm_state_s st_d;
   logic [31:0] fs_src;
   logic [127:0] pin_src;
   logic [fsprm_pkg::PINS-1:0] pb_in;
   logic [3:0] w_idx;
   logic [3:0] r_idx;

   // Maps a byte address onto a register index, IDX_NONE when unmapped
   function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
      logic [7:0] a;
      a = 8'(addr);
      if (addr[1:0] != 2'h0 || addr > ADDR_W'(fsprm_pkg::OFS_STAT)) begin
         reg_index = fsprm_pkg::IDX_NONE;
      end else begin
         reg_index = 4'((a - fsprm_pkg::OFS_FS0) >> 2);
      end
   endfunction

   // Merges a write into a register under byte strobes and writable bits
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] wmask);
      logic [31:0] bm;
      for (int b = 0; b < 4; b++) begin
         bm[b*8 +: 8] = {8{strb[b]}};
      end
      merge = (old & ~(bm & wmask)) | (nw & bm & wmask);
   endfunction

   always_comb begin
      fs_src = 32'h0;
      fs_src[fsprm_pkg::FS_C_PB +: fsprm_pkg::PINS] = PB_OUT;
      fs_src[fsprm_pkg::FS_C_SPFS +: fsprm_pkg::PORTS] = SP_FSYNC_OUT;
      fs_src[fsprm_pkg::FS_C_RXFS] = SPDIF_RX_FSYNC_OUT;
      fs_src[fsprm_pkg::FS_C_TXBI] = SPDIF_TX_BIPHASE_OUT;
      fs_src[fsprm_pkg::FS_C_PRECA] = PRECISION_FSYNC_A_OUT;
      fs_src[fsprm_pkg::FS_C_PRECB] = PRECISION_FSYNC_B_OUT;
      fs_src[fsprm_pkg::FS_C_LOW] = 1'b0;
      fs_src[fsprm_pkg::FS_C_HIGH] = 1'b1;
   end

   always_comb begin
      pin_src = 128'h0;
      pin_src[fsprm_pkg::PN_C_PB +: fsprm_pkg::PINS] = PB_OUT;
      for (int k = 0; k < fsprm_pkg::PORTS; k++) begin
         pin_src[fsprm_pkg::PN_C_SPDAT + 2*k] = SP_DATA_A_OUT[k];
         pin_src[fsprm_pkg::PN_C_SPDAT + 2*k + 1] = SP_DATA_B_OUT[k];
      end
      pin_src[fsprm_pkg::PN_C_SPCLK +: fsprm_pkg::PORTS] = SP_CLOCK_OUT;
      pin_src[fsprm_pkg::PN_C_SPFS +: fsprm_pkg::PORTS] = SP_FSYNC_OUT;
      pin_src[fsprm_pkg::PN_C_AUX +: fsprm_pkg::AUX_N] = AUX_SRC & ~fsprm_pkg::AUX_RSVD;
      pin_src[fsprm_pkg::PN_C_LOW] = 1'b0;
      pin_src[fsprm_pkg::PN_C_HIGH] = 1'b1;
   end

   genvar gi;
   generate
      for (gi = 0; gi < fsprm_pkg::FS_DESTS; gi++) begin : g_fs
         logic [fsprm_pkg::FS_W-1:0] sel;
         assign sel = st_q.fs[gi / fsprm_pkg::FS_PER_REG][(gi % fsprm_pkg::FS_PER_REG) * fsprm_pkg::FS_W +:
                                                             fsprm_pkg::FS_W];
         assign FS_DEST[gi] = fs_src[sel];
      end
      for (gi = 0; gi < fsprm_pkg::PINS; gi++) begin : g_pin
         logic [fsprm_pkg::PIN_W-1:0] sel;
         logic inv;
         assign sel = st_q.pin[gi / fsprm_pkg::PIN_PER_REG][(gi % fsprm_pkg::PIN_PER_REG) * fsprm_pkg::PIN_W +:
                                                               fsprm_pkg::PIN_W];
         if (gi == fsprm_pkg::PB19) begin : g_inv19
            assign inv = st_q.pin[fsprm_pkg::PIN_REGS-1][fsprm_pkg::INV19_BIT] &&
                         (sel != 7'(fsprm_pkg::PB19));
         end else if (gi == fsprm_pkg::PB20) begin : g_inv20
            assign inv = st_q.pin[fsprm_pkg::PIN_REGS-1][fsprm_pkg::INV20_BIT] &&
                         (sel != 7'(fsprm_pkg::PB20));
         end else begin : g_noinv
            assign inv = 1'b0;
         end
         assign pb_in[gi] = pin_src[sel] ^ inv;
      end
   endgenerate

   assign PB_IN = pb_in;

   // Bus handshakes
   assign AWREADY = CE && !st_q.aw_got && !st_q.b_valid;
   assign WREADY = CE && !st_q.w_got && !st_q.b_valid;
   assign ARREADY = CE && !st_q.r_valid;
   assign BVALID = st_q.b_valid;
   assign BRESP = st_q.b_resp;
   assign RVALID = st_q.r_valid;
   assign RDATA = st_q.r_data;
   assign RRESP = st_q.r_resp;

   assign w_idx = reg_index(st_q.aw_addr);
   assign r_idx = reg_index(ARADDR);

   always_comb begin
      st_d = st_q;
      if (CE) begin
         // Address and data are captured in either order
         if (AWVALID && AWREADY) begin
            st_d.aw_got = 1'b1;
            st_d.aw_addr = AWADDR;
         end
         if (WVALID && WREADY) begin
            st_d.w_got = 1'b1;
            st_d.w_data = WDATA;
            st_d.w_strb = WSTRB;
         end
         // Register update once both halves are held
         if (st_q.aw_got && st_q.w_got && !st_q.b_valid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.b_valid = 1'b1;
            st_d.b_resp = fsprm_pkg::RESP_OKAY;
            if (w_idx < fsprm_pkg::IDX_PIN0) begin
               st_d.fs[w_idx[1:0]] = merge(st_q.fs[w_idx[1:0]], st_q.w_data, st_q.w_strb,
                                           fsprm_pkg::FS_WMASK);
            end else if (w_idx < fsprm_pkg::IDX_STAT) begin
               st_d.pin[3'(w_idx - fsprm_pkg::IDX_PIN0)] =
                  merge(st_q.pin[3'(w_idx - fsprm_pkg::IDX_PIN0)], st_q.w_data, st_q.w_strb,
                        (w_idx == fsprm_pkg::IDX_STAT - 4'h1) ? fsprm_pkg::PIN4_WMASK :
                                                                 fsprm_pkg::PIN_WMASK);
            end else if (w_idx != fsprm_pkg::IDX_STAT) begin
               st_d.b_resp = fsprm_pkg::RESP_SLVERR;
            end
         end
         if (st_q.b_valid && BREADY) begin
            st_d.b_valid = 1'b0;
         end
         // Read answer: configuration or live pin buffer inputs
         if (st_q.r_valid && RREADY) begin
            st_d.r_valid = 1'b0;
         end
         if (ARVALID && ARREADY) begin
            st_d.r_valid = 1'b1;
            st_d.r_resp = fsprm_pkg::RESP_OKAY;
            if (r_idx < fsprm_pkg::IDX_PIN0) begin
               st_d.r_data = st_q.fs[r_idx[1:0]];
            end else if (r_idx < fsprm_pkg::IDX_STAT) begin
               st_d.r_data = st_q.pin[3'(r_idx - fsprm_pkg::IDX_PIN0)];
            end else if (r_idx == fsprm_pkg::IDX_STAT) begin
               st_d.r_data = 32'(pb_in);
            end else begin
               st_d.r_data = 32'h0000_0000;
               st_d.r_resp = fsprm_pkg::RESP_SLVERR;
            end
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_q.fs <= {fsprm_pkg::FS_REGS{fsprm_pkg::RST_ROUTE}};
         st_q.pin <= {fsprm_pkg::PIN_REGS{fsprm_pkg::RST_ROUTE}};
         st_q.aw_got <= 1'b0;
         st_q.aw_addr <= '0;
         st_q.w_got <= 1'b0;
         st_q.w_data <= 32'h0000_0000;
         st_q.w_strb <= 4'h0;
         st_q.b_valid <= 1'b0;
         st_q.b_resp <= 2'h0;
         st_q.r_valid <= 1'b0;
         st_q.r_data <= 32'h0000_0000;
         st_q.r_resp <= 2'h0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

// ===== fsprm_partner.sv
// Source model for the crossbar: peripherals and pin buffers.
// Draws fresh random levels at each rising clock edge while step is high.
`timescale 1ns/1ps
module fsprm_partner (
   // Clock and update request
   input wire logic CLK,
   input wire logic step,
   // Pin buffer outputs
   output logic [19:0] PB_OUT,
   // Serial port outputs
   output logic [5:0] SP_FSYNC_OUT,
   output logic [5:0] SP_CLOCK_OUT,
   output logic [5:0] SP_DATA_A_OUT,
   output logic [5:0] SP_DATA_B_OUT,
   // S/PDIF and precision frame-sync outputs
   output logic SPDIF_RX_FSYNC_OUT,
   output logic SPDIF_TX_BIPHASE_OUT,
   output logic PRECISION_FSYNC_A_OUT,
   output logic PRECISION_FSYNC_B_OUT,
   // Other pin-routing sources
   output logic [35:0] AUX_SRC
);
   logic [83:0] lv = 84'h0;
   assign {AUX_SRC, PRECISION_FSYNC_B_OUT, PRECISION_FSYNC_A_OUT, SPDIF_TX_BIPHASE_OUT, SPDIF_RX_FSYNC_OUT,
      SP_DATA_B_OUT, SP_DATA_A_OUT, SP_CLOCK_OUT, SP_FSYNC_OUT, PB_OUT} = lv;
   always @(posedge CLK) if (step) lv <= 84'({$urandom, $urandom, $urandom});
endmodule

// ===== fsprm_checker.sv
// Port checker: bus handshakes, status word and routing after reset.
// Bound into fsprm_top; one clock domain, asynchronous reset.
`timescale 1ns/1ps
module fsprm_checker #(parameter int ADDR_W = 8) (
   // Clock, reset, enable
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   // Bus
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic [1:0] BRESP,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic [31:0] RDATA,
   // Routing
   input wire logic [19:0] PB_OUT,
   input wire logic [19:0] PB_IN,
   input wire logic [15:0] FS_DEST
);
   logic fresh_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // No write accepted since reset
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) fresh_q <= 1'b1;
      else if (AWVALID && AWREADY) fresh_q <= 1'b0;
   end
   sequence wr_take;
      CE && AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence rd_take;
      CE && ARVALID && ARREADY;
   endsequence
   chk_write_resp: assert property (wr_take |-> ##2 BVALID)
      else $error("write response late");
   chk_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   chk_read_resp: assert property (rd_take |=> RVALID)
      else $error("read data late");
   chk_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   chk_aw_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write taken during response");
   chk_ar_refuse: assert property (RVALID |-> !ARREADY)
      else $error("read taken during response");
   chk_ce_gate: assert property (!CE |-> !AWREADY && !WREADY && !ARREADY)
      else $error("request taken while disabled");
   chk_reset_route: assert property (fresh_q |-> FS_DEST == {16{PB_OUT[0]}} && PB_IN == {20{PB_OUT[0]}})
      else $error("routing after reset wrong");
   chk_status_read: assert property (rd_take ##0 ARADDR == ADDR_W'(8'h24) |=> RDATA == {12'h000, $past(PB_IN)})
      else $error("status word wrong");
endmodule

// ===== test_frame_sync_and_pin_routing_mux.sv
// Bench for the routing crossbar: bus master, source model, result queues.
// Assumes fsprm_top with ADDR_W 8 and a 100 MHz clock.
`timescale 1ns/1ps
module test_frame_sync_and_pin_routing_mux;
   logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, step = 1'b0;
   logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
   logic [31:0] WDATA = 32'h0, RDATA;
   logic [3:0] WSTRB = 4'h0;
   logic [1:0] BRESP, RRESP, inv;
   logic [19:0] PB_OUT, PB_IN;
   logic [5:0] SP_FSYNC_OUT, SP_CLOCK_OUT, SP_DATA_A_OUT, SP_DATA_B_OUT;
   logic SPDIF_RX_FSYNC_OUT, SPDIF_TX_BIPHASE_OUT, PRECISION_FSYNC_A_OUT, PRECISION_FSYNC_B_OUT;
   logic [35:0] AUX_SRC;
   logic [15:0] FS_DEST;
   logic [83:0] src;
   logic [4:0] fs_sh [16];
   logic [6:0] pin_sh [20];
   logic [1:0] bq [$];
   logic [33:0] rq [$], rd_exp;
   int miscompares = 0, tests_run = 0, d;
   assign src = {AUX_SRC, PRECISION_FSYNC_B_OUT, PRECISION_FSYNC_A_OUT, SPDIF_TX_BIPHASE_OUT,
      SPDIF_RX_FSYNC_OUT, SP_DATA_B_OUT, SP_DATA_A_OUT, SP_CLOCK_OUT, SP_FSYNC_OUT, PB_OUT};
   initial forever #5 CLK = ~CLK;
   fsprm_partner peer (
      .CLK(CLK), .step(step), .PB_OUT(PB_OUT),
      .SP_FSYNC_OUT(SP_FSYNC_OUT), .SP_CLOCK_OUT(SP_CLOCK_OUT), .SP_DATA_A_OUT(SP_DATA_A_OUT),
      .SP_DATA_B_OUT(SP_DATA_B_OUT), .SPDIF_RX_FSYNC_OUT(SPDIF_RX_FSYNC_OUT),
      .SPDIF_TX_BIPHASE_OUT(SPDIF_TX_BIPHASE_OUT), .PRECISION_FSYNC_A_OUT(PRECISION_FSYNC_A_OUT),
      .PRECISION_FSYNC_B_OUT(PRECISION_FSYNC_B_OUT), .AUX_SRC(AUX_SRC)
   );
   fsprm_top uut (
      .CLK(CLK), .RST(RST), .CE(CE),
      .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
      .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
      .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .PB_OUT(PB_OUT), .PB_IN(PB_IN),
      .SP_FSYNC_OUT(SP_FSYNC_OUT), .SP_CLOCK_OUT(SP_CLOCK_OUT), .SP_DATA_A_OUT(SP_DATA_A_OUT),
      .SP_DATA_B_OUT(SP_DATA_B_OUT), .SPDIF_RX_FSYNC_OUT(SPDIF_RX_FSYNC_OUT),
      .SPDIF_TX_BIPHASE_OUT(SPDIF_TX_BIPHASE_OUT), .PRECISION_FSYNC_A_OUT(PRECISION_FSYNC_A_OUT),
      .PRECISION_FSYNC_B_OUT(PRECISION_FSYNC_B_OUT), .AUX_SRC(AUX_SRC), .FS_DEST(FS_DEST)
   );
   function automatic logic fs_src(logic [4:0] c);
      logic [31:0] v;
      v = {2'b10, src[47:44], src[25:0]};
      return v[c];
   endfunction
   function automatic logic pin_src(logic [6:0] c);
      logic [127:0] v;
      v = {46'h0, 2'b10, src[83:48] & ~36'hE0, src[25:20], src[31:26], 12'h000, src[19:0]};
      for (int k = 0; k < 6; k++) v[20+2*k+:2] = {src[38+k], src[32+k]};
      return v[c];
   endfunction
   function automatic logic [19:0] exp_pb();
      logic [19:0] e;
      foreach (e[i]) e[i] = pin_src(pin_sh[i]);
      e[18] ^= inv[0] && pin_sh[18] !== 7'h12;
      e[19] ^= inv[1] && pin_sh[19] !== 7'h13;
      return e;
   endfunction
   function automatic logic [31:0] reg_val(int r);
      if (r < 4) return {12'h000, fs_sh[4*r+3], fs_sh[4*r+2], fs_sh[4*r+1], fs_sh[4*r]};
      if (r < 9) return {2'b00, (r == 8) ? inv : 2'b00, pin_sh[4*r-13], pin_sh[4*r-14],
         pin_sh[4*r-15], pin_sh[4*r-16]};
      return {12'h000, exp_pb()};
   endfunction
   task automatic check(string what, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic xfer(bit rdn, logic [7:0] a, logic [31:0] dat, logic [3:0] s, logic [33:0] e);
      bit done = 1'b0;
      int hold = $urandom % 4;
      @(posedge CLK);
      if (rdn) begin
         rq.push_back(e);
         ARADDR <= a;
         ARVALID <= 1'b1;
      end else begin
         bq.push_back(e[1:0]);
         AWADDR <= a;
         WDATA <= dat;
         WSTRB <= s;
         AWVALID <= 1'b1;
         WVALID <= 1'b1;
      end
      for (int n = 0; !done; n++) begin
         // Late ready lets the response wait on the bus
         if (n == hold) begin
            BREADY <= !rdn;
            RREADY <= rdn;
         end
         @(posedge CLK);
         if (n == 40) begin
            miscompares++;
            end_sim();
         end
         if (AWREADY) AWVALID <= 1'b0;
         if (WREADY) WVALID <= 1'b0;
         if (ARREADY) ARVALID <= 1'b0;
         done = BVALID && BREADY || RVALID && RREADY;
      end
      BREADY <= 1'b0;
      RREADY <= 1'b0;
   endtask
   task automatic route();
      logic [15:0] ef;
      @(negedge CLK);
      foreach (ef[i]) ef[i] = fs_src(fs_sh[i]);
      check("fs_dest", 32'(ef), 32'(FS_DEST));
      check("pb_in", 32'(exp_pb()), 32'(PB_IN));
   endtask
   task automatic put(int r);
      xfer(1'b0, 8'(4 * r), reg_val(r), 4'hF, 34'h0);
      route();
   endtask
   task automatic rd(int r);
      xfer(1'b1, 8'(4 * r), 32'h0, 4'h0, {2'b00, reg_val(r)});
   endtask
   task automatic restart();
      @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      foreach (fs_sh[i]) fs_sh[i] = 5'h00;
      foreach (pin_sh[i]) pin_sh[i] = 7'h00;
      inv = 2'b00;
      route();
      for (int r = 0; r < 10; r++) rd(r);
   endtask
   always @(posedge CLK) begin
      if (BVALID && BREADY) check("bresp", 32'(bq.pop_front()), 32'(BRESP));
      if (RVALID && RREADY) begin
         rd_exp = rq.pop_front();
         check("rdata", rd_exp[31:0], RDATA);
         check("rresp", 32'(rd_exp[33:32]), 32'(RRESP));
      end
   end
   initial begin
      void'($urandom(1));
      restart();
      for (int r = 0; r < 10; r++) xfer(1'b0, 8'(4 * r), 32'hFFFFFFFF, 4'hF, 34'h0);
      foreach (fs_sh[i]) fs_sh[i] = 5'h1F;
      foreach (pin_sh[i]) pin_sh[i] = 7'h7F;
      inv = 2'b11;
      for (int r = 0; r < 10; r++) rd(r);
      xfer(1'b0, 8'h00, 32'h0, 4'h1, 34'h0);
      fs_sh[0] = 5'h00;
      fs_sh[1] = 5'h18;
      rd(0);
      xfer(1'b0, 8'h28, 32'h0, 4'hF, 34'h2);
      xfer(1'b0, 8'h01, 32'h0, 4'hF, 34'h2);
      xfer(1'b1, 8'h02, 32'h0, 4'h0, 34'h2_0000_0000);
      route();
      // Requests wait while the block is disabled
      @(posedge CLK);
      CE <= 1'b0;
      fork
         put(1);
         begin
            repeat (3) @(posedge CLK);
            CE <= 1'b1;
         end
      join
      step <= 1'b1;
      for (int k = 0; k < 64; k++) begin
         d = $urandom % 16;
         fs_sh[d] = 5'(k);
         put(d / 4);
      end
      for (int k = 0; k < 256; k++) begin
         d = k % 20;
         pin_sh[d] = 7'(k % 82);
         if (d > 15) inv = 2'($urandom);
         put(4 + d / 4);
      end
      pin_sh[18] = 7'h12;
      pin_sh[19] = 7'h13;
      inv = 2'b11;
      put(8);
      pin_sh[18] = 7'h13;
      pin_sh[19] = 7'h12;
      put(8);
      step <= 1'b0;
      restart();
      end_sim();
   end
endmodule
bind fsprm_top fsprm_checker #(.ADDR_W(ADDR_W)) chk (
   .CLK(CLK), .RST(RST), .CE(CE),
   .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
   .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
   .RVALID(RVALID), .RREADY(RREADY), .BRESP(BRESP), .ARADDR(ARADDR), .RDATA(RDATA),
   .PB_OUT(PB_OUT), .PB_IN(PB_IN), .FS_DEST(FS_DEST)
);
